/* quad_conv_pkg.sv */
// constants, types and timing counts for the absolute to quadrature converter
// Functional notes
// - locked mode samples only on a controller incremental strobe
// - free-running mode samples and emits the change every millisecond
// - emit new minus held position, then hold the new position
// - A leads B for positive motion, B leads A for negative
// - quadrature edges leave at a fixed rate, whatever the backlog
// - one count is one edge on either channel; controller decodes 4X
// - absolute request streams the whole absolute position as counts
// - absolute streaming always runs positive, A leading B
// - output starts from power-up without any absolute update
// - transducer fault: red flashes, quadrature stops, relay drops
// - reserved mode selector setting raises a configuration fault
// - missing serial data signal raises a transducer fault
// - no position within 100 ms raises a timeout fault
// - strobe fault: red/green alternate, free-run fallback, relay drops
// - locked mode flags loss when incremental strobes stop
// - missing second absolute pulse in its window raises a fault
// - strobe timing violations raise a strobe-cycle fault
// - absolute request clears an incremental strobe loss fault
// - internal fault: both red solid, both outputs stop, relays drop
// - no fault, no strobe yet: green flashes, axis runs free
// - waiting locked axis takes either strobe; free axis only absolute
// - after a strobe with no fault: solid green, configured mode, relay on
// - one common reset serves both axes
// - resolution 0..B gives 2^7..2^18, C..F give 2^21,22,24,25
// - mode bit3 multi turn, bit2 binary, bit1 free-run, odd reserved
package quad_conv_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int QUAD_HZ = 800_000;
    localparam int EDGE_CYC = CLK_HZ / (QUAD_HZ * 4);
    localparam logic [6:0] EDGE_LAST = 7'(EDGE_CYC - 1);
    localparam int FREE_US = 1000;
    localparam int FREE_CYC = CLK_HZ / 1_000_000 * FREE_US;
    localparam int TMO_MS = 100;
    localparam int TMO_CYC = CLK_HZ / 1000 * TMO_MS;
    localparam int STB_MIN_NS = 1000;
    localparam int STB_MIN_CYC = (STB_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ABS_PULSE_US = 10;
    localparam int ABS_PULSE_CYC = CLK_HZ / 1_000_000 * ABS_PULSE_US;
    localparam int ABS_WIN_US = 20;
    localparam int ABS_WIN_CYC = CLK_HZ / 1_000_000 * ABS_WIN_US;
    localparam int INC_MIN_US = 100;
    localparam int INC_MIN_CYC = CLK_HZ / 1_000_000 * INC_MIN_US;
    localparam int INC_LOSS_MS = 5;
    localparam int INC_LOSS_CYC = CLK_HZ / 1000 * INC_LOSS_MS;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int CW = 26;
    localparam logic [7:0] A_CFG0 = 8'h00;
    localparam logic [7:0] A_CFG1 = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam int MODE_RSV = 0;
    localparam int MODE_FREE = 1;
    localparam int MODE_BIN = 2;
    localparam int MODE_MULTI = 3;
    localparam int ST_HW_BIT = 16;
    localparam int ST_RELAY_LSB = 17;
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_RUN = 2'b01,
        ST_ABS = 2'b10
    } axst_e;
endpackage : quad_conv_pkg

/* quad_emitter.sv */
// quadrature edge generator with pending count accumulator
`timescale 1ns/1ps
module quad_emitter
    import quad_conv_pkg::*;
#(
    parameter int PW = 33
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // control
    input wire logic inhibit,
    input wire logic load,
    input wire logic signed [PW-1:0] loadVal,
    // outputs
    output logic chA,
    output logic chB,
    output logic idle
);
    typedef struct packed {
        logic signed [PW+1:0] pend;
        logic [6:0] div;
        logic [1:0] ph;
        logic a;
        logic b;
        logic idle;
    } qe_s;

    qe_s state_ff;
    qe_s nxt_state;

    always_comb begin
        logic stepOk;
        logic signed [PW+1:0] p;
        stepOk = 1'b0;
        p = '0;
        nxt_state = state_ff;
        if (state_ff.div == EDGE_LAST) begin
            nxt_state.div = '0;
            stepOk = 1'b1;
        end else begin
            nxt_state.div = state_ff.div + 7'h01;
        end
        if (inhibit) begin
            nxt_state.pend = '0;
            nxt_state.div = '0;
        end else begin
            p = state_ff.pend;
            if (load) begin
                p = p + (PW + 2)'(loadVal);
            end
            if (stepOk && p > 0) begin
                nxt_state.ph = state_ff.ph + 2'h1;
                p = p - (PW + 2)'(1);
            end else if (stepOk && p < 0) begin
                nxt_state.ph = state_ff.ph - 2'h1;
                p = p + (PW + 2)'(1);
            end
            nxt_state.pend = p;
        end
        nxt_state.a = nxt_state.ph[1] ^ nxt_state.ph[0];
        nxt_state.b = nxt_state.ph[1];
        nxt_state.idle = (nxt_state.pend == '0);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_ff <= '{pend: '0, div: '0, ph: '0, a: 1'b0, b: 1'b0, idle: 1'b1};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign chA = state_ff.a;
    assign chB = state_ff.b;
    assign idle = state_ff.idle;
endmodule : quad_emitter

/* abs_quad_converter.sv */
// two-axis absolute position to 4x quadrature converter with wishbone registers
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module abs_quad_converter
    import quad_conv_pkg::*;
#(
    parameter int FREE_P = FREE_CYC,
    parameter int TMO_P = TMO_CYC,
    parameter int INC_MIN_P = INC_MIN_CYC,
    parameter int INC_LOSS_P = INC_LOSS_CYC,
    parameter int BLINK_P = BLINK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // controller strobes, active low pins
    input wire logic [1:0] strobeN,
    // transducer side
    input wire logic [1:0] serialDataMissing,
    input wire logic internalFault,
    output logic [1:0] sampleReq,
    input wire logic [1:0] posValid,
    input wire logic [1:0][31:0] posData,
    // quadrature outputs
    output logic [1:0] chA,
    output logic [1:0] chB,
    // indicators and relays
    output logic [1:0] ledRed,
    output logic [1:0] ledGreen,
    output logic [1:0] relayOn
);
    typedef struct packed {
        axst_e st;
        logic stbPrev;
        logic [CW-1:0] wid;
        logic [CW-1:0] gap;
        logic [CW-1:0] tmo;
        logic absArm;
        logic incSeen;
        logic absFlag;
        logic waitPos;
        logic refOk;
        logic [31:0] refPos;
        logic ldV;
        logic signed [32:0] ldVal;
        logic req;
        logic fTmo;
        logic fAbsLoss;
        logic fIncLoss;
        logic fTiming;
        logic inh;
        logic red;
        logic green;
        logic relay;
    } axis_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [1:0][7:0] cfg;
        logic [1:0] stbS1;
        logic [1:0] stbS2;
        logic [1:0] lbS1;
        logic [1:0] lbS2;
        logic hwS1;
        logic hwS2;
        logic [CW-1:0] tick;
        logic [CW-1:0] blink;
        logic blinkOn;
        axis_s [1:0] ax;
    } top_s;

    function automatic logic [CW-1:0] satInc(input logic [CW-1:0] v);
        return (v == '1) ? v : v + CW'(1);
    endfunction : satInc

    function automatic logic [4:0] resBits(input logic [3:0] sel);
        unique case (sel)
            4'hc: return 5'd21;
            4'hd: return 5'd22;
            4'he: return 5'd24;
            4'hf: return 5'd25;
            default: return 5'(sel) + 5'h07;
        endcase
    endfunction : resBits

    function automatic logic [31:0] posConv(input logic [31:0] raw, input logic [7:0] cfg);
        logic [31:0] v;
        logic [4:0] nb;
        v = raw;
        nb = resBits(cfg[3:0]);
        if (!cfg[4 + MODE_BIN]) begin
            for (int k = 30; k >= 0; k--) begin
                v[k] = v[k+1] ^ raw[k];
            end
        end
        if (!cfg[4 + MODE_MULTI]) begin
            v = v & ((32'h1 << nb) - 32'h1);
        end
        return v;
    endfunction : posConv

    function automatic logic signed [32:0] wrapDelta(input logic [31:0] d, input logic [7:0] cfg);
        logic [31:0] t;
        logic [5:0] sh;
        t = d;
        sh = 6'h00;
        if (!cfg[4 + MODE_MULTI]) begin
            sh = 6'd32 - {1'b0, resBits(cfg[3:0])};
            t = d << sh;
            t = 32'($signed(t) >>> sh);
        end
        return {t[31], t};
    endfunction : wrapDelta

    logic [1:0] rstSync_ff;
    logic rstN;
    top_s state_ff;
    top_s nxt_state;
    logic [1:0] quadIdle;

    // reset release synchroniser, common to both axes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstSync_ff <= 2'b00;
        end else begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end
    assign rstN = rstSync_ff[1];

    always_comb begin
        logic [1:0] fall;
        logic [1:0] absReq;
        logic [1:0] incStb;
        logic [1:0] viol;
        logic [1:0] absLossEv;
        logic [1:0] incLossEv;
        logic [1:0] locked;
        logic [1:0] cfgErr;
        logic [1:0] xf;
        logic [1:0] ef;
        logic [1:0] trig;
        logic [31:0] p;
        logic tickHit;
        logic hw;
        fall = '0;
        absReq = '0;
        incStb = '0;
        viol = '0;
        absLossEv = '0;
        incLossEv = '0;
        locked = '0;
        cfgErr = '0;
        xf = '0;
        ef = '0;
        trig = '0;
        p = '0;
        tickHit = 1'b0;
        hw = 1'b0;
        nxt_state = state_ff;
        // pin synchronisers
        nxt_state.stbS1 = ~strobeN;
        nxt_state.stbS2 = state_ff.stbS1;
        nxt_state.lbS1 = serialDataMissing;
        nxt_state.lbS2 = state_ff.lbS1;
        nxt_state.hwS1 = internalFault;
        nxt_state.hwS2 = state_ff.hwS1;
        hw = state_ff.hwS2;
        // millisecond timebase and blink timer
        tickHit = (state_ff.tick == CW'(FREE_P - 1));
        nxt_state.tick = tickHit ? '0 : state_ff.tick + CW'(1);
        if (state_ff.blink == CW'(BLINK_P - 1)) begin
            nxt_state.blink = '0;
            nxt_state.blinkOn = !state_ff.blinkOn;
        end else begin
            nxt_state.blink = state_ff.blink + CW'(1);
        end
        // wishbone slave, one wait state, ack drops after one cycle
        nxt_state.ack = cyc_i && stb_i && !state_ff.ack;
        nxt_state.rdat = '0;
        if (cyc_i && stb_i && !state_ff.ack) begin
            case (adr_i)
                A_CFG0: begin
                    nxt_state.rdat = {24'h000000, state_ff.cfg[0]};
                    if (we_i && sel_i[0]) begin
                        nxt_state.cfg[0] = dat_i[7:0];
                    end
                end
                A_CFG1: begin
                    nxt_state.rdat = {24'h000000, state_ff.cfg[1]};
                    if (we_i && sel_i[0]) begin
                        nxt_state.cfg[1] = dat_i[7:0];
                    end
                end
                A_STAT: begin
                    for (int i = 0; i < 2; i++) begin
                        nxt_state.rdat[i*8 +: 8] = {state_ff.ax[i].fTiming,
                            state_ff.ax[i].fIncLoss, state_ff.ax[i].fAbsLoss,
                            state_ff.ax[i].fTmo, state_ff.lbS2[i],
                            state_ff.cfg[i][4 + MODE_RSV], state_ff.ax[i].st};
                        nxt_state.rdat[ST_RELAY_LSB + i] = state_ff.ax[i].relay;
                    end
                    nxt_state.rdat[ST_HW_BIT] = hw;
                end
                default: nxt_state.rdat = '0;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            cfgErr[i] = state_ff.cfg[i][4 + MODE_RSV];
            locked[i] = !state_ff.cfg[i][4 + MODE_FREE];
            xf[i] = cfgErr[i] | state_ff.lbS2[i] | state_ff.ax[i].fTmo;
            ef[i] = state_ff.ax[i].fAbsLoss | state_ff.ax[i].fIncLoss
                | state_ff.ax[i].fTiming;
            // strobe pulse classification at the end of each pulse
            fall[i] = state_ff.ax[i].stbPrev && !state_ff.stbS2[i];
            nxt_state.ax[i].stbPrev = state_ff.stbS2[i];
            nxt_state.ax[i].wid = state_ff.stbS2[i] ? satInc(state_ff.ax[i].wid) : '0;
            nxt_state.ax[i].gap = fall[i] ? '0 : satInc(state_ff.ax[i].gap);
            if (fall[i]) begin
                if (state_ff.ax[i].wid < CW'(STB_MIN_CYC)) begin
                    viol[i] = 1'b1;
                end else if (state_ff.ax[i].absArm) begin
                    absReq[i] = 1'b1;
                    nxt_state.ax[i].absArm = 1'b0;
                end else if (state_ff.ax[i].wid >= CW'(ABS_PULSE_CYC)) begin
                    nxt_state.ax[i].absArm = 1'b1;
                end else if (state_ff.ax[i].incSeen
                        && state_ff.ax[i].gap < CW'(INC_MIN_P)) begin
                    viol[i] = 1'b1;
                end else begin
                    incStb[i] = 1'b1;
                    nxt_state.ax[i].incSeen = 1'b1;
                end
            end else if (state_ff.ax[i].absArm
                    && state_ff.ax[i].gap >= CW'(ABS_WIN_CYC)) begin
                absLossEv[i] = 1'b1;
                nxt_state.ax[i].absArm = 1'b0;
            end
            incLossEv[i] = locked[i] && state_ff.ax[i].st == ST_RUN
                && state_ff.ax[i].incSeen && !state_ff.stbS2[i]
                && state_ff.ax[i].gap >= CW'(INC_LOSS_P);
            nxt_state.ax[i].fTiming = viol[i] | state_ff.ax[i].fTiming;
            nxt_state.ax[i].fAbsLoss = absLossEv[i] | state_ff.ax[i].fAbsLoss;
            nxt_state.ax[i].fIncLoss = incLossEv[i] | (state_ff.ax[i].fIncLoss && !absReq[i]);
            // axis state
            unique case (state_ff.ax[i].st)
                ST_WAIT: begin
                    if (absReq[i]) begin
                        nxt_state.ax[i].st = ST_ABS;
                    end else if (incStb[i] && locked[i]) begin
                        nxt_state.ax[i].st = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (absReq[i]) begin
                        nxt_state.ax[i].st = ST_ABS;
                    end
                end
                ST_ABS: begin
                    if (!state_ff.ax[i].absFlag && !state_ff.ax[i].waitPos
                            && !state_ff.ax[i].ldV && quadIdle[i]) begin
                        nxt_state.ax[i].st = ST_RUN;
                    end
                end
                default: nxt_state.ax[i].st = ST_WAIT;
            endcase
            // sample trigger: timebase when running free, strobe when locked
            if (!locked[i] || state_ff.ax[i].st == ST_WAIT || ef[i]) begin
                trig[i] = tickHit && state_ff.ax[i].st != ST_ABS;
            end else begin
                trig[i] = incStb[i] && state_ff.ax[i].st != ST_ABS;
            end
            nxt_state.ax[i].req = 1'b0;
            nxt_state.ax[i].ldV = 1'b0;
            nxt_state.ax[i].tmo = posValid[i] ? '0 : satInc(state_ff.ax[i].tmo);
            nxt_state.ax[i].fTmo = !posValid[i]
                && (state_ff.ax[i].fTmo || state_ff.ax[i].tmo >= CW'(TMO_P - 1));
            if (posValid[i]) begin
                nxt_state.ax[i].waitPos = 1'b0;
                p = posConv(posData[i], state_ff.cfg[i]);
                nxt_state.ax[i].refPos = p;
                nxt_state.ax[i].refOk = 1'b1;
                if (state_ff.ax[i].absFlag) begin
                    nxt_state.ax[i].ldV = 1'b1;
                    nxt_state.ax[i].ldVal = {1'b0, p};
                    nxt_state.ax[i].absFlag = 1'b0;
                end else if (state_ff.ax[i].refOk) begin
                    nxt_state.ax[i].ldV = 1'b1;
                    nxt_state.ax[i].ldVal = wrapDelta(p - state_ff.ax[i].refPos,
                        state_ff.cfg[i]);
                end
            end
            if (absReq[i]) begin
                nxt_state.ax[i].absFlag = 1'b1;
            end
            if ((trig[i] || absReq[i]) && (!state_ff.ax[i].waitPos || posValid[i])) begin
                nxt_state.ax[i].req = 1'b1;
                nxt_state.ax[i].waitPos = 1'b1;
            end
            // indicators, relay and output inhibit
            nxt_state.ax[i].inh = xf[i] | hw;
            nxt_state.ax[i].relay = !(xf[i] | hw | ef[i]);
            if (hw) begin
                nxt_state.ax[i].red = 1'b1;
                nxt_state.ax[i].green = 1'b0;
            end else if (xf[i]) begin
                nxt_state.ax[i].red = state_ff.blinkOn;
                nxt_state.ax[i].green = 1'b0;
            end else if (ef[i]) begin
                nxt_state.ax[i].red = state_ff.blinkOn;
                nxt_state.ax[i].green = !state_ff.blinkOn;
            end else if (state_ff.ax[i].st == ST_WAIT) begin
                nxt_state.ax[i].red = 1'b0;
                nxt_state.ax[i].green = state_ff.blinkOn;
            end else begin
                nxt_state.ax[i].red = 1'b0;
                nxt_state.ax[i].green = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : gAxis
        quad_emitter #(
            .PW(33)
        ) uQuad (
            .clk(clk),
            .rstN(rstN),
            .inhibit(state_ff.ax[g].inh),
            .load(state_ff.ax[g].ldV),
            .loadVal(state_ff.ax[g].ldVal),
            .chA(chA[g]),
            .chB(chB[g]),
            .idle(quadIdle[g])
        );
        assign sampleReq[g] = state_ff.ax[g].req;
        assign ledRed[g] = state_ff.ax[g].red;
        assign ledGreen[g] = state_ff.ax[g].green;
        assign relayOn[g] = state_ff.ax[g].relay;
    end

    assign dat_o = state_ff.rdat;
    assign ack_o = state_ff.ack;
endmodule : abs_quad_converter

/* abs_quad_converter_sva.sv */
// concurrent checks on the converter top ports
`timescale 1ns/1ps
module abs_quad_converter_sva (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // fault pins
    input wire logic [1:0] serialDataMissing,
    input wire logic internalFault,
    // outputs
    input wire logic [1:0] chA,
    input wire logic [1:0] chB,
    input wire logic [1:0] ledRed,
    input wire logic [1:0] ledGreen,
    input wire logic [1:0] relayOn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic prevA_ff;
    logic prevB_ff;
    logic [7:0] gap_ff;
    wire logic stepA = chA[0] ^ prevA_ff;
    wire logic stepB = chB[0] ^ prevB_ff;
    // cycles since the last edge on axis 0, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevA_ff <= 1'h0;
            prevB_ff <= 1'h0;
            gap_ff <= 8'hff;
        end else begin
            prevA_ff <= chA[0];
            prevB_ff <= chB[0];
            gap_ff <= (stepA | stepB) ? 8'h00 : gap_ff + 8'(gap_ff != 8'hff);
        end
    end
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_intFault;
        internalFault [*6];
    endsequence
    sequence s_lineLoss;
        serialDataMissing[1] [*6];
    endsequence
    a_ack_next: assert property (s_req |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
    a_int_stop: assert property (s_intFault |=> relayOn == 2'h0 && ledRed == 2'h3
        && ledGreen == 2'h0) else $error("internal fault not shown");
    a_one_edge: assert property (!(stepA && stepB)) else $error("double edge");
    a_edge_rate: assert property (stepA || stepB |-> gap_ff >= 8'h3d)
        else $error("edges too close");
    a_line_stop: assert property (s_lineLoss |=> !relayOn[1] && !ledGreen[1])
        else $error("line loss not shown");
    a_line_hold: assert property (s_lineLoss |=> $stable(chA[1]) && $stable(chB[1]))
        else $error("output moved under fault");
endmodule : abs_quad_converter_sva

bind abs_quad_converter abs_quad_converter_sva chk_u (
    .clk(clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .serialDataMissing(serialDataMissing), .internalFault(internalFault), .chA(chA),
    .chB(chB), .ledRed(ledRed), .ledGreen(ledGreen), .relayOn(relayOn));

/* ctrl_model.sv */
// motion controller model: strobe pulses out, 4x quadrature decode in
`timescale 1ns/1ps
module ctrl_model (
    // clock
    input wire logic clk,
    // quadrature in
    input wire logic [1:0] chA,
    input wire logic [1:0] chB,
    // strobe pins, active low, idle high
    output logic [1:0] strobeN
);
    int cnt [2] = '{0, 0};
    int negCnt [2] = '{0, 0};
    int badCnt = 0;
    logic [1:0] prevA = 2'h0;
    logic [1:0] prevB = 2'h0;
    logic [1:0] step;
    initial strobeN = 2'h3;
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            step = {chB[i], chA[i] ^ chB[i]} - {prevB[i], prevA[i] ^ prevB[i]};
            if (step == 2'h1) begin
                cnt[i]++;
            end else if (step == 2'h3) begin
                cnt[i]--;
                negCnt[i]++;
            end else if (step == 2'h2) begin
                badCnt++;
            end
        end
        prevA <= chA;
        prevB <= chB;
    end
    task automatic pulse(input int ax, input int w);
        @(posedge clk);
        strobeN[ax] <= 1'h0;
        repeat (w) @(posedge clk);
        strobeN[ax] <= 1'h1;
    endtask : pulse
endmodule : ctrl_model

/* tb_top.sv */
// self-checking bench for the two-axis quadrature converter
`timescale 1ns/1ps
module tb_top
    import quad_conv_pkg::*;
;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat, r;
    logic ack, intFault = 1'h0;
    logic [1:0] strobeN, sampleReq, chA, chB, ledRed, ledGreen, relayOn;
    logic [1:0] lineLoss = 2'h0;
    logic [1:0] posValid = 2'h0;
    logic [1:0] mute = 2'h0;
    logic [1:0][31:0] pos = {32'h64, 32'h0c};
    logic [1:0][31:0] posData = 64'h0;
    int errorCnt = 0;
    int totalChecks = 0;
    int b;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} row_s;
    row_s rows [10] = '{'{1'h0, A_CFG0, 32'h0, 4'hf, 32'h0}, '{1'h1, A_CFG0, 32'h8b, 4'hf, 32'h0},
        '{1'h1, A_CFG1, 32'h6b, 4'h1, 32'h0}, '{1'h1, A_CFG1, 32'h0, 4'he, 32'h0},
        '{1'h1, A_STAT, 32'hffffffff, 4'hf, 32'h0}, '{1'h1, 8'h0c, 32'hff, 4'hf, 32'h0},
        '{1'h0, A_CFG0, 32'h0, 4'hf, 32'h8b}, '{1'h0, A_CFG1, 32'h0, 4'hf, 32'h6b},
        '{1'h0, 8'h0c, 32'h0, 4'hf, 32'h0}, '{1'h0, A_STAT, 32'h0, 4'hf, 32'h00060000}};
    initial begin
        forever #2.5 clk = ~clk;
    end
    abs_quad_converter #(.FREE_P(200), .TMO_P(5000), .INC_MIN_P(50), .INC_LOSS_P(2000),
        .BLINK_P(16)) dut_u (
        .clk(clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .strobeN(strobeN),
        .serialDataMissing(lineLoss), .internalFault(intFault), .sampleReq(sampleReq),
        .posValid(posValid), .posData(posData), .chA(chA), .chB(chB), .ledRed(ledRed),
        .ledGreen(ledGreen), .relayOn(relayOn));
    ctrl_model ctl_u (.clk(clk), .chA(chA), .chB(chB), .strobeN(strobeN));
    // transducer stand-in: axis 0 gray, axis 1 binary, one cycle after each request
    always @(posedge clk) begin
        posValid <= sampleReq & ~mute;
        posData[0] <= pos[0] ^ (pos[0] >> 1);
        posData[1] <= pos[1];
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic reportAndStop();
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : reportAndStop
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1);
        q = rdat;
        {cyc, stb} <= 2'h0;
        check(32'(n), 32'h2);
    endtask : bus
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles
    // one and a half free-run periods plus the edge time of n counts
    task automatic settle(input int n);
        cycles(300 + n * EDGE_CYC);
    endtask : settle
    task automatic count(input int ax, input int base, input int n);
        check(32'(ctl_u.cnt[ax] - base), 32'(n));
    endtask : count
    task automatic absReq(input int ax);
        ctl_u.pulse(ax, 2100);
        cycles(100);
        ctl_u.pulse(ax, 300);
        cycles(10);
    endtask : absReq
    initial begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        reportAndStop();
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        cycles(3);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, rows[i].s, r);
            if (!rows[i].w) check(r, rows[i].e);
        end
        cycles(200);
        b = ctl_u.cnt[1];
        pos[1] <= 32'h78;
        settle(20);
        count(1, b, 20);
        check(32'({ledRed[1], relayOn[1]}), 32'h1);
        pos[1] <= 32'h71;
        settle(7);
        count(1, b, 13);
        ctl_u.pulse(1, 300);
        cycles(10);
        bus(1'h0, A_STAT, 32'h0, 4'hf, r);
        check(32'(r[9:8]), 32'h0);
        b = ctl_u.cnt[0];
        absReq(0);
        settle(12);
        count(0, b, 12);
        check(32'(ctl_u.negCnt[0]), 32'h0);
        repeat (2) begin
            check(32'({ledGreen[0], ledRed[0], relayOn[0]}), 32'h5);
            cycles(17);
        end
        pos[0] <= 32'h25;
        cycles(250);
        count(0, b, 12);
        ctl_u.pulse(0, 300);
        settle(25);
        count(0, b, 37);
        cycles(600);
        check(32'({ledGreen[0] ^ ledRed[0], relayOn[0]}), 32'h2);
        pos[0] <= 32'h2a;
        settle(5);
        count(0, b, 42);
        b = ctl_u.cnt[0];
        absReq(0);
        bus(1'h0, A_STAT, 32'h0, 4'hf, r);
        check(32'(r[6]), 32'h0);
        settle(42);
        count(0, b, 42);
        ctl_u.pulse(0, 50);
        ctl_u.pulse(0, 2100);
        cycles(4200);
        bus(1'h0, A_STAT, 32'h0, 4'hf, r);
        check(32'({r[7], r[5]}), 32'h3);
        bus(1'h1, A_CFG1, 32'h7b, 4'h1, r);
        mute[1] <= 1'h1;
        lineLoss[1] <= 1'h1;
        cycles(5100);
        bus(1'h0, A_STAT, 32'h0, 4'hf, r);
        check(32'({r[12:10], relayOn[1]}), 32'he);
        intFault <= 1'h1;
        cycles(10);
        check(32'({ledRed, relayOn}), 32'hc);
        {intFault, lineLoss, mute, nrst} <= 6'h0;
        cycles(3);
        nrst <= 1'h1;
        cycles(5);
        check(32'(relayOn), 32'h3);
        bus(1'h0, A_CFG1, 32'h0, 4'hf, r);
        check(r, 32'h0);
        check(32'(ctl_u.badCnt), 32'h0);
        reportAndStop();
    end
endmodule : tb_top
